// ==== swbr_receiver.sv ====
`default_nettype none

module swbr_receiver #(
    parameter int         CNT_W          = swbr_pkg::CNT_W,
    parameter int         MAX_PERIOD_CYC = swbr_pkg::BIT_PERIOD_MAX_CYC,
    parameter logic [7:0] END_MULT       = 8'(swbr_pkg::PACKET_END_MULT),
    parameter logic [7:0] LATCH_MULT     = 8'(swbr_pkg::LATCH_HOLD_MULT),
    parameter int         GRAY_TICK_DIV  = swbr_pkg::GRAY_TICK_DIV
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Serial link
    input  wire logic       serial_in,
    output var  logic       serial_out,
    // Sink drivers
    output var  logic [2:0] sink_output
);

    localparam logic [CNT_W-1:0] MAX_P = CNT_W'(MAX_PERIOD_CYC);
    localparam logic [CNT_W-1:0] MIN_P = CNT_W'(swbr_pkg::BIT_PERIOD_MIN_CYC);

    // Saturating cycle count
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        return (c == {CNT_W{1'b1}}) ? c : c + 1'b1;
    endfunction

    // Hold threshold from period and multiple
    function automatic logic [CNT_W-1:0] hold_limit(input logic [CNT_W-1:0] p,
                                                    input logic [7:0] m);
        logic [CNT_W+7:0] prod;
        prod = {8'h00, p} * {{CNT_W{1'b0}}, m};
        return prod[CNT_W-1:0];
    endfunction

    swbr_pkg::swbr_state_t state_r;
    logic [2:0]            sync_r;
    logic                  in_level_r;
    logic                  in_prev_r;
    logic                  rise;
    logic [CNT_W-1:0]      bit_cnt_r;
    logic [CNT_W-1:0]      low_cnt_r;
    logic [CNT_W-1:0]      period_r;
    logic [CNT_W-1:0]      half_w;
    logic [CNT_W-1:0]      end_limit;
    logic [CNT_W-1:0]      latch_limit;
    logic                  decided_r;
    logic [31:0]           shift_r;
    logic                  end_hit;
    logic                  latch_fire;
    logic                  cmd_ok;
    logic                  load_r;
    swbr_pwm_if            pwm_bus ();

    // ----------------------------------------------------------------
    // Input synchroniser and edge detect
    // ----------------------------------------------------------------
    // Level moves only when stages two and three agree
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync_r     <= swbr_pkg::SYNC_RESET;
            in_level_r <= 1'b0;
            in_prev_r  <= 1'b0;
        end else begin
            sync_r     <= {sync_r[1:0], serial_in};
            in_level_r <= (sync_r[1] == sync_r[2]) ? sync_r[2] : in_level_r;
            in_prev_r  <= in_level_r;
        end
    end
    assign rise = in_level_r & ~in_prev_r;

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // Low time; a high level restarts it
    always_ff @(posedge clock) begin
        if (!reset_n || in_level_r) begin
            low_cnt_r <= '0;
        end else begin
            low_cnt_r <= sat_inc(low_cnt_r);
        end
    end

    assign end_limit   = hold_limit(period_r, END_MULT);
    assign latch_limit = hold_limit(period_r, LATCH_MULT);
    assign half_w      = period_r >> 1;
    assign end_hit     = (state_r == swbr_pkg::ST_RECEIVE) && (low_cnt_r >= end_limit);
    assign latch_fire  = (state_r == swbr_pkg::ST_FORWARD) && (low_cnt_r >= latch_limit);
    assign cmd_ok      = (shift_r[swbr_pkg::CMD_LSB +: 8] == swbr_pkg::WRITE_CMD);

    // ----------------------------------------------------------------
    // Receive state machine
    // ----------------------------------------------------------------
    // Bit timer counts elapsed cycles since the last bit start edge
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r   <= swbr_pkg::ST_WAIT_FIRST;
            bit_cnt_r <= '0;
            period_r  <= '0;
            decided_r <= 1'b1;
            shift_r   <= swbr_pkg::SHIFT_RESET;
        end else begin
            bit_cnt_r <= sat_inc(bit_cnt_r);
            case (state_r)
                swbr_pkg::ST_WAIT_FIRST: begin
                    if (rise) begin
                        bit_cnt_r <= CNT_W'(1);
                        state_r   <= swbr_pkg::ST_MEASURE;
                    end
                end
                swbr_pkg::ST_MEASURE: begin
                    if (rise) begin
                        bit_cnt_r <= CNT_W'(1);
                        // edge gap in cycles
                        // A gap beyond the longest period restarts measuring here
                        // accepted periods: any gap up to the longest, no lower bound
                        if (bit_cnt_r <= MAX_P) begin
                            period_r  <= bit_cnt_r;
                            shift_r   <= {shift_r[29:0], 2'b00};
                            decided_r <= 1'b1;
                            state_r   <= swbr_pkg::ST_RECEIVE;
                        end
                    end
                end
                swbr_pkg::ST_RECEIVE: begin
                    if (end_hit) begin
                        if (!decided_r) begin
                            shift_r <= {shift_r[30:0], 1'b0};
                        end
                        decided_r <= 1'b1;
                        state_r   <= swbr_pkg::ST_FORWARD;
                    end else if (rise) begin
                        if (bit_cnt_r >= half_w) begin
                            if (!decided_r) begin
                                shift_r <= {shift_r[30:0], 1'b0};
                            end
                            decided_r <= 1'b0;
                            bit_cnt_r <= CNT_W'(1);
                        end else if (!decided_r) begin
                            shift_r   <= {shift_r[30:0], 1'b1};
                            decided_r <= 1'b1;
                        end
                    end
                end
                swbr_pkg::ST_FORWARD: begin
                    // Latch ends forwarding and rearms measuring
                    if (latch_fire) begin
                        state_r <= swbr_pkg::ST_WAIT_FIRST;
                    end
                end
                default: begin
                    state_r <= swbr_pkg::ST_WAIT_FIRST;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Forwarding and latch strobe
    // ----------------------------------------------------------------
    // buffered pass-through
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= (state_r == swbr_pkg::ST_FORWARD) && in_level_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            load_r <= 1'b0;
        end else begin
            load_r <= latch_fire && cmd_ok;
        end
    end

    assign pwm_bus.load = load_r;
    assign pwm_bus.data = shift_r[swbr_pkg::CH0_LSB +: 24];

    swbr_pwm #(
        .GRAY_TICK_DIV (GRAY_TICK_DIV)
    ) u_pwm (
        .clock       (clock),
        .reset_n     (reset_n),
        .pwm         (pwm_bus.sink),
        .sink_output (sink_output)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    period_store_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_MEASURE) && rise && (bit_cnt_r <= MAX_P)
        |=> (period_r == $past(bit_cnt_r)) && (state_r == swbr_pkg::ST_RECEIVE))
        else $error("bit period not stored");

    range_accept_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_MEASURE) && rise && (bit_cnt_r >= MIN_P)
        && (bit_cnt_r <= MAX_P) |=> (state_r == swbr_pkg::ST_RECEIVE))
        else $error("legal bit period refused");

    measure_zeros_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_MEASURE) && rise && (bit_cnt_r <= MAX_P)
        |=> (shift_r[1:0] == 2'b00) && (shift_r[31:2] == $past(shift_r[29:0])))
        else $error("measuring did not shift two zeros");

    one_decode_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_RECEIVE) && !end_hit && rise && !decided_r
        && (bit_cnt_r < half_w) |=> shift_r[0] && decided_r)
        else $error("early edge not decoded as one");

    zero_decode_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_RECEIVE) && !end_hit && rise && !decided_r
        && (bit_cnt_r >= half_w) |=> !shift_r[0] && (bit_cnt_r == CNT_W'(1)))
        else $error("late edge not decoded as zero");

    packet_end_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        end_hit |=> (state_r == swbr_pkg::ST_FORWARD) && (latch_limit > end_limit))
        else $error("packet end hold not taken");

    frozen_shift_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_FORWARD) |=> $stable(shift_r))
        else $error("shift register moved while frozen");

    forward_copy_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (state_r == swbr_pkg::ST_FORWARD) ##1 (state_r == swbr_pkg::ST_FORWARD)
        |-> (serial_out == $past(in_level_r)))
        else $error("serial out not following input");

    cmd_gate_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        latch_fire && !cmd_ok |=> !load_r && (state_r == swbr_pkg::ST_WAIT_FIRST))
        else $error("latch loaded with wrong command");

    latch_load_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        latch_fire && cmd_ok |=> load_r ##1 !load_r)
        else $error("latch strobe missing or long");

endmodule

`default_nettype wire

// ==== swbr_pkg.sv ====
`default_nettype none

package swbr_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int BIT_PERIOD_MIN_NS  = 1000;
    localparam int BIT_PERIOD_MAX_NS  = 50000;
    // Least time rounds up, longest rounds down
    localparam int BIT_PERIOD_MIN_CYC = (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_PERIOD_MAX_CYC = BIT_PERIOD_MAX_NS / CLK_PERIOD_NS;
    // Hold thresholds as multiples of the measured bit period
    localparam int PACKET_END_MULT    = 4;
    localparam int LATCH_HOLD_MULT    = 8;
    // About 6 MHz grayscale tick from the 100 MHz clock
    localparam int GRAY_TICK_DIV      = 17;
    localparam int CNT_W              = 20;

    // ----------------------------------------------------------------
    // Packet layout
    // ----------------------------------------------------------------
    localparam int         PKT_W         = 32;
    localparam int         LEVEL_W       = 8;
    localparam int         NUM_CH        = 3;
    localparam int         CH0_LSB       = 0;
    localparam int         CH1_LSB       = 8;
    localparam int         CH2_LSB       = 16;
    localparam int         CMD_LSB       = 24;
    localparam logic [7:0] WRITE_CMD     = 8'h3a;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] SHIFT_RESET  = 32'h0000_0000;
    localparam logic [23:0] LEVEL_RESET  = 24'h00_0000;
    localparam logic [7:0]  GRAY_RESET   = 8'h00;
    localparam logic [2:0]  SINK_RESET   = 3'h0;
    localparam logic [2:0]  SYNC_RESET   = 3'h0;

    // Receiver states, one-hot
    typedef enum logic [3:0] {
        ST_WAIT_FIRST = 4'h1,
        ST_MEASURE    = 4'h2,
        ST_RECEIVE    = 4'h4,
        ST_FORWARD    = 4'h8
    } swbr_state_t;

endpackage

`default_nettype wire

// ==== swbr_pwm_if.sv ====
`default_nettype none

// Latch strobe and brightness data from receiver to PWM
interface swbr_pwm_if;
    logic        load;
    logic [23:0] data;

    modport src  (output load, output data);
    modport sink (input load, input data);
endinterface

`default_nettype wire

// ==== swbr_pwm.sv ====
`default_nettype none

module swbr_pwm #(
    parameter int GRAY_TICK_DIV = swbr_pkg::GRAY_TICK_DIV
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // From receiver
    swbr_pwm_if.sink        pwm,
    // Sink drivers, high turns a sink on
    output var  logic [2:0] sink_output
);

    // ----------------------------------------------------------------
    // Grayscale tick divider
    // ----------------------------------------------------------------
    localparam int DIV_W = $clog2(GRAY_TICK_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(GRAY_TICK_DIV - 1);

    logic [DIV_W-1:0]  div_r;
    logic              grayscale_tick;
    logic [7:0]        gray_cnt_r;
    logic [23:0]       level_r;

    // Divider restarts on load so PWM begins on the next tick
    always_ff @(posedge clock) begin
        if (!reset_n || pwm.load) begin
            div_r <= '0;
        end else if (div_r == DIV_LAST) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign grayscale_tick = (div_r == DIV_LAST);

    // ----------------------------------------------------------------
    // Brightness latch and grayscale counter
    // ----------------------------------------------------------------
    // latch copy
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            level_r <= swbr_pkg::LEVEL_RESET;
        end else if (pwm.load) begin
            level_r <= pwm.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n || pwm.load) begin
            gray_cnt_r <= swbr_pkg::GRAY_RESET;
        end else if (grayscale_tick) begin
            gray_cnt_r <= gray_cnt_r + 8'h01;
        end
    end

    // On from count 1 while count does not exceed the level
    // off until latched
    always_ff @(posedge clock) begin
        if (!reset_n || pwm.load) begin
            sink_output <= swbr_pkg::SINK_RESET;
        end else begin
            for (int i = 0; i < swbr_pkg::NUM_CH; i++) begin
                sink_output[i] <= (gray_cnt_r != 8'h00)
                    && (gray_cnt_r <= level_r[i*swbr_pkg::LEVEL_W +: swbr_pkg::LEVEL_W]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    load_forces_off_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        pwm.load |=> (sink_output == 3'h0) && (gray_cnt_r == 8'h00) ##1 (sink_output == 3'h0))
        else $error("outputs not forced off after load");

    dark_until_load_a: assert property (
        @(posedge clock) disable iff (!reset_n)
        (level_r == 24'h00_0000) |=> (sink_output == 3'h0))
        else $error("sink on with zero brightness");

endmodule

`default_nettype wire

// ==== swbr_host_model.sv ====
`default_nettype none

// Host controller stand-in that drives the single-wire link
module swbr_host_model (
    // Clock
    input  wire logic clock,
    // Serial line toward the device
    output var  logic serial_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Line drive
    // ----------------------------------------------------------------
    // Idle line sits low, so no stray rising edge before the first frame
    initial begin
        serial_in = 1'b0;
    end

    // Every change lands just after a clock edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One bit cell: a start pulse, plus a second pulse at 3/8 cell for a one
    task automatic send_bit(input int p, input logic b);
        serial_in = 1'b1;
        wait_cyc(p / 8);
        serial_in = 1'b0;
        wait_cyc(p / 4);
        if (b) begin
            serial_in = 1'b1;
        end
        wait_cyc(p / 8);
        serial_in = 1'b0;
        wait_cyc(p - p / 8 - p / 4 - p / 8);
    endtask

    // ----------------------------------------------------------------
    // Packets
    // ----------------------------------------------------------------
    // period pair then 30 bits, MSB first
    task automatic send_packet(input int p, input logic [31:0] data);
        for (int i = 31; i >= 0; i--) begin
            send_bit(p, data[i]);
        end
    endtask

    // line held low, packet end or latch by its length
    task automatic hold_low(input int n);
        serial_in = 1'b0;
        wait_cyc(n);
    endtask

    // one packet per device, same period, latch at the end
    task automatic send_chain(input int p, input logic [31:0] own, input logic [31:0] next);
        send_packet(p, own);
        hold_low(6 * p);
        send_packet(p, next);
        hold_low(14 * p);
    endtask
endmodule

`default_nettype wire

// ==== swbr_receiver_tb_top.sv ====
`default_nettype none

module swbr_receiver_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Settings and signals
    // ----------------------------------------------------------------
    localparam int P_FAST = 100;    // 1 us bit period
    localparam int P_SLOW = 400;
    localparam int DIV    = 2;      // Short grayscale tick keeps PWM frames brief
    localparam int FRAME  = 256 * DIV;

    logic       clock;
    logic       reset_n;
    logic       serial_in;
    logic       serial_out;
    logic [2:0] sink_output;
    int         failures;
    int         comparisons;
    int         out_rises;
    int         sink_highs;
    int         on_cnt [3];
    logic       out_prev;

    swbr_receiver #(
        .GRAY_TICK_DIV (DIV)
    ) dut_u (
        .clock       (clock),
        .reset_n     (reset_n),
        .serial_in   (serial_in),
        .serial_out  (serial_out),
        .sink_output (sink_output)
    );

    swbr_host_model host_u (
        .clock     (clock),
        .serial_in (serial_in)
    );

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Activity counters, cleared by the scenarios
    always @(posedge clock) begin
        if (serial_out === 1'b1 && out_prev !== 1'b1)
            out_rises++;
        if (sink_output !== 3'h0)
            sink_highs++;
        for (int c = 0; c < 3; c++)
            if (sink_output[c] === 1'b1)
                on_cnt[c]++;
        out_prev <= serial_out;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Whole frames only, so the count does not depend on PWM phase
    task automatic check_pwm(input logic [23:0] lv);
        repeat (FRAME) @(posedge clock);
        #1;
        for (int c = 0; c < 3; c++)
            on_cnt[c] = 0;
        repeat (4 * FRAME) @(posedge clock);
        #1;
        for (int c = 0; c < 3; c++)
            check($sformatf("sink %0d on cycles", c), 32'(4 * DIV * lv[8*c +: 8]),
                  32'(on_cnt[c]));
    endtask

    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("serial_out after reset", 32'h0, 32'(serial_out));
        check("sinks after reset", 32'h0, 32'(sink_output));
        $display("test reset done");
    endtask

    // Own packet kept, second packet forwarded, then one latch for both
    task automatic t_chain();
        logic [31:0] own;
        logic [31:0] next;
        own        = {swbr_pkg::WRITE_CMD, 8'hff, 8'h80, 8'h10};
        next       = {swbr_pkg::WRITE_CMD, 8'h03, 8'h5a, 8'h01};
        out_rises  = 0;
        sink_highs = 0;
        host_u.send_packet(P_FAST, own);
        host_u.hold_low(6 * P_FAST);
        check("rises before packet end", 32'h0, 32'(out_rises));
        host_u.send_packet(P_FAST, next);
        check("sink activity before latch", 32'h0, 32'(sink_highs));
        host_u.hold_low(14 * P_FAST);
        check("forwarded rises", 32'(32 + $countones(next)), 32'(out_rises));
        check_pwm(own[23:0]);
        $display("test chain done");
    endtask

    // Wrong command byte leaves the running levels alone
    task automatic t_wrong_cmd();
        host_u.send_packet(P_FAST, {8'h3b, 8'h44, 8'h44, 8'h44});
        host_u.hold_low(14 * P_FAST);
        check_pwm(24'hff_8010);
        $display("test wrong command done");
    endtask

    // Period measured again after a latch, at a slower rate
    task automatic t_slow();
        logic [31:0] pkt;
        pkt = {swbr_pkg::WRITE_CMD, 8'h00, 8'h33, 8'hfe};
        host_u.send_packet(P_SLOW, pkt);
        host_u.hold_low(14 * P_SLOW);
        check_pwm(pkt[23:0]);
        $display("test slow period done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        reset_n     = 1'b0;
        failures    = 0;
        comparisons = 0;
        out_rises   = 0;
        sink_highs  = 0;
        out_prev    = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        reset_n = 1'b1;
        @(posedge clock);
        #1;
        t_reset();
        t_chain();
        t_wrong_cmd();
        t_slow();
        test_done();
    end

    // Tests need about 39000 cycles; this limit leaves ample margin
    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        test_done();
    end
endmodule

`default_nettype wire
